// file: design/e1oba_pkg.sv
// Summary of operation
// [RULE_01] Received international and additional bits go into the receive words exactly as they arrive, unchecked.
// [RULE_02] Both receive words are refreshed in the cycle that raises the receive align frame flag.
// [RULE_03] The host reads the receive words within 250 us of the receive flag, or the values are overwritten.
// [RULE_04] Both transmit words are sampled when the transmit align frame flag is raised and feed the outgoing overhead.
// [RULE_05] The host updates the transmit words within 250 us of the transmit flag, else the old contents are resent.
// [RULE_06] The international bit is replaced when sourced from serial input, in CRC4 mode, or with automatic E-bit insertion.
// [RULE_07] The additional bits are replaced whenever any of transmit control bits 3 to 7 is one.
// [RULE_08] The receive align word holds the international bit in bit 7 and the seven alignment bits in bits 6 to 0.
// [RULE_09] The receive non-align word holds international, marker, remote alarm and additional bits 4 to 8, bit 7 down.
// [RULE_10] The host writes the alignment pattern 0011011 into bits 6 to 0 of the transmit align word.
// [RULE_11] The host writes a one into bit 6 of the transmit non-align word.
// [RULE_12] Transmit non-align bit 5 goes out as remote alarm, bit 7 as international, bits 4 to 0 as additional bits.
// [RULE_13] Align words go with alignment frames, non-align words with the alternate frames, on both directions.
// [RULE_14] Each align frame flag is raised once per two-frame period, in step with its direction's frame timing.
package e1oba_pkg;

    localparam logic [7:0] OFS_TX_ALIGN_WORD    = 8'h20;
    localparam logic [7:0] OFS_TX_NONALIGN_WORD = 8'h21;
    localparam logic [7:0] OFS_RX_ALIGN_WORD    = 8'h28;
    localparam logic [7:0] OFS_RX_NONALIGN_WORD = 8'h29;

    localparam logic [7:0] RST_TX_ALIGN_WORD    = 8'h00;
    localparam logic [7:0] RST_TX_NONALIGN_WORD = 8'h00;
    localparam logic [7:0] RST_RX_WORD          = 8'h00;
    localparam logic [7:0] READ_UNMAPPED        = 8'h00;

    localparam int SI_BIT  = 7;
    localparam int NAM_BIT = 6;
    localparam int RAI_BIT = 5;
    localparam int SA_HI   = 4;
    localparam int SA_LO   = 0;
    localparam int TCR_SA_HI = 7;
    localparam int TCR_SA_LO = 3;

    localparam logic [6:0] FAS_PATTERN = 7'h1B;

endpackage

// file: design/e1oba_ts0_if.sv
`timescale 1ns/1ps
// one time-slot-zero octet and its frame type
interface e1oba_ts0_if;
    logic       valid;
    logic       align;
    logic [7:0] data;

    modport prod (output valid, output align, output data);
    modport cons (input valid, input align, input data);
endinterface

// file: design/e1oba_rx_capture.sv
`timescale 1ns/1ps
module e1oba_rx_capture (
    input  wire logic  clk,
    input  wire logic  rst_n,
    e1oba_ts0_if.cons  ts0,
    output logic [7:0] align_word,
    output logic [7:0] nonalign_word,
    output logic       align_flag
);
    logic [7:0] pend_nonalign;
    logic [7:0] next_pend_nonalign;
    logic [7:0] next_align_word;
    logic [7:0] next_nonalign_word;
    logic       next_align_flag;

    // non-align octet waits in a shadow so both words change together
    always_comb begin
        next_pend_nonalign = pend_nonalign;
        next_align_word    = align_word;
        next_nonalign_word = nonalign_word;
        next_align_flag    = 1'b0;
        if (ts0.valid && !ts0.align) begin
            next_pend_nonalign = ts0.data;                 // RULE_13
        end
        if (ts0.valid && ts0.align) begin
            next_align_word    = ts0.data;                 // RULE_01
            next_nonalign_word = pend_nonalign;            // RULE_02
            next_align_flag    = 1'b1;                     // RULE_14
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_nonalign <= e1oba_pkg::RST_RX_WORD;
            align_word    <= e1oba_pkg::RST_RX_WORD;
            nonalign_word <= e1oba_pkg::RST_RX_WORD;
            align_flag    <= 1'b0;
        end else begin
            pend_nonalign <= next_pend_nonalign;
            align_word    <= next_align_word;
            nonalign_word <= next_nonalign_word;
            align_flag    <= next_align_flag;
        end
    end

    rx_raw_bits_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
        ts0.valid && ts0.align |=> align_word == $past(ts0.data))
        else $error("receive align word differs from line octet");
    rx_pair_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_02
        ts0.valid && ts0.align |=> nonalign_word == $past(pend_nonalign) && align_flag)
        else $error("receive non-align word not refreshed with flag");
    rx_flag_cause_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_14
        $rose(align_flag) || align_flag |-> $past(ts0.valid && ts0.align))
        else $error("receive flag without align frame");
    rx_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_13
        !(ts0.valid && ts0.align) |=> $stable(align_word) && $stable(nonalign_word))
        else $error("receive words changed outside align frame");
endmodule

// file: design/e1oba_tx_insert.sv
`timescale 1ns/1ps
module e1oba_tx_insert (
    input  wire logic       clk,
    input  wire logic       rst_n,
    e1oba_ts0_if.cons       req,
    input  wire logic [7:0] align_reg,
    input  wire logic [7:0] nonalign_reg,
    input  wire logic       si_override,
    input  wire logic       sa_override,
    output logic            out_valid,
    output logic [7:0]      out_data,
    output logic            align_flag
);
    logic [7:0] samp_align;
    logic [7:0] samp_nonalign;
    logic [7:0] next_samp_align;
    logic [7:0] next_samp_nonalign;
    logic       next_out_valid;
    logic [7:0] next_out_data;
    logic       next_align_flag;
    logic [7:0] word;

    always_comb begin
        next_samp_align    = samp_align;
        next_samp_nonalign = samp_nonalign;
        next_align_flag    = 1'b0;
        next_out_valid     = req.valid;
        if (req.valid && req.align) begin
            next_samp_align    = align_reg;                // RULE_04
            next_samp_nonalign = nonalign_reg;             // RULE_04
            next_align_flag    = 1'b1;                     // RULE_14
        end
        // align frame uses the value sampled right now, not the stale copy
        word = req.align ? align_reg : samp_nonalign;      // RULE_13 RULE_05
        if (si_override) begin
            word[e1oba_pkg::SI_BIT] = req.data[e1oba_pkg::SI_BIT];              // RULE_06
        end
        // marker and remote alarm always come from the register
        if (sa_override && !req.align) begin
            word[e1oba_pkg::SA_HI:e1oba_pkg::SA_LO] =
                req.data[e1oba_pkg::SA_HI:e1oba_pkg::SA_LO];                    // RULE_07
        end
        next_out_data = req.valid ? word : out_data;       // RULE_12
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            samp_align    <= e1oba_pkg::RST_TX_ALIGN_WORD;
            samp_nonalign <= e1oba_pkg::RST_TX_NONALIGN_WORD;
            out_valid     <= 1'b0;
            out_data      <= 8'h00;
            align_flag    <= 1'b0;
        end else begin
            samp_align    <= next_samp_align;
            samp_nonalign <= next_samp_nonalign;
            out_valid     <= next_out_valid;
            out_data      <= next_out_data;
            align_flag    <= next_align_flag;
        end
    end

    tx_sample_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
        req.valid && req.align |=> samp_nonalign == $past(nonalign_reg) && align_flag)
        else $error("transmit words not sampled at flag");
    tx_resend_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_05
        !(req.valid && req.align) |=> $stable(samp_nonalign))
        else $error("transmit sample changed without flag");
    tx_si_sub_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_06
        req.valid && si_override |=> out_data[7] == $past(req.data[7]))
        else $error("international bit not replaced");
    tx_sa_sub_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
        req.valid && !req.align && sa_override |=> out_data[4:0] == $past(req.data[4:0]))
        else $error("additional bits not replaced");
    tx_nonalign_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_12
        req.valid && !req.align && !sa_override && !si_override
        |=> out_data == $past(samp_nonalign))
        else $error("non-align octet differs from sampled word");
    tx_align_oct_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_13
        req.valid && req.align |=> out_data[6:0] == $past(align_reg[6:0]) && out_valid)
        else $error("align octet differs from align word");
endmodule

// file: design/e1oba_top.sv
`timescale 1ns/1ps
module e1oba_top (
    input  wire logic       MCLK,
    input  wire logic       RST_N,
    input  wire logic [7:0] HOST_ADDR,
    input  wire logic [7:0] HOST_WDATA,
    input  wire logic       HOST_WR,
    input  wire logic       HOST_RD,
    output logic [7:0]      HOST_RDATA,
    input  wire logic       RX_TS0_VALID,
    input  wire logic       RX_TS0_ALIGN,
    input  wire logic [7:0] RX_TS0_DATA,
    input  wire logic       TX_TS0_REQ,
    input  wire logic       TX_TS0_ALIGN,
    input  wire logic       TX_SI_ALT,
    input  wire logic [4:0] TX_SA_ALT,
    input  wire logic       TX_SI_SERIAL,
    input  wire logic       TX_CRC4_EN,
    input  wire logic       TX_AUTO_EBIT,
    input  wire logic [7:0] TX_CTRL_REG,
    output logic            TX_TS0_VALID,
    output logic [7:0]      TX_TS0_DATA,
    output logic            RX_ALIGN_FLAG,
    output logic            TX_ALIGN_FLAG
);
    ////////////////////////////////////////////////////////////////////////////////
    // host registers

    logic [7:0] tx_align_word;
    logic [7:0] tx_nonalign_word;
    logic [7:0] next_tx_align_word;
    logic [7:0] next_tx_nonalign_word;
    logic [7:0] next_host_rdata;
    logic [7:0] read_mux;
    logic [7:0] rx_align_word;
    logic [7:0] rx_nonalign_word;

    // host strobes share MCLK with the framer, so no retiming
    always_comb begin
        next_tx_align_word    = tx_align_word;
        next_tx_nonalign_word = tx_nonalign_word;
        if (HOST_WR && HOST_ADDR == e1oba_pkg::OFS_TX_ALIGN_WORD) begin
            next_tx_align_word = HOST_WDATA;
        end
        if (HOST_WR && HOST_ADDR == e1oba_pkg::OFS_TX_NONALIGN_WORD) begin
            next_tx_nonalign_word = HOST_WDATA;
        end
        case (HOST_ADDR)
            e1oba_pkg::OFS_TX_ALIGN_WORD:    read_mux = tx_align_word;
            e1oba_pkg::OFS_TX_NONALIGN_WORD: read_mux = tx_nonalign_word;
            e1oba_pkg::OFS_RX_ALIGN_WORD:    read_mux = rx_align_word;     // RULE_08
            e1oba_pkg::OFS_RX_NONALIGN_WORD: read_mux = rx_nonalign_word;  // RULE_09
            default:                         read_mux = e1oba_pkg::READ_UNMAPPED;
        endcase
        // rdata holds until the next read so a slow host sees a steady value
        next_host_rdata = HOST_RD ? read_mux : HOST_RDATA;
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            tx_align_word    <= e1oba_pkg::RST_TX_ALIGN_WORD;
            tx_nonalign_word <= e1oba_pkg::RST_TX_NONALIGN_WORD;
            HOST_RDATA       <= e1oba_pkg::READ_UNMAPPED;
        end else begin
            tx_align_word    <= next_tx_align_word;
            tx_nonalign_word <= next_tx_nonalign_word;
            HOST_RDATA       <= next_host_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // receive capture

    e1oba_ts0_if rx_ts0 ();

    assign rx_ts0.valid = RX_TS0_VALID;
    assign rx_ts0.align = RX_TS0_ALIGN;
    assign rx_ts0.data  = RX_TS0_DATA;

    e1oba_rx_capture u_rx (
        .clk           (MCLK),
        .rst_n         (RST_N),
        .ts0           (rx_ts0.cons),
        .align_word    (rx_align_word),
        .nonalign_word (rx_nonalign_word),
        .align_flag    (RX_ALIGN_FLAG)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // transmit insertion

    e1oba_ts0_if tx_req ();
    logic si_override;
    logic sa_override;

    // alternate bits ride in the request octet at their own positions
    assign tx_req.valid = TX_TS0_REQ;
    assign tx_req.align = TX_TS0_ALIGN;
    assign tx_req.data  = {TX_SI_ALT, 2'b00, TX_SA_ALT};
    assign si_override  = TX_SI_SERIAL | TX_CRC4_EN | TX_AUTO_EBIT;                       // RULE_06
    assign sa_override  = |TX_CTRL_REG[e1oba_pkg::TCR_SA_HI:e1oba_pkg::TCR_SA_LO];       // RULE_07

    e1oba_tx_insert u_tx (
        .clk          (MCLK),
        .rst_n        (RST_N),
        .req          (tx_req.cons),
        .align_reg    (tx_align_word),
        .nonalign_reg (tx_nonalign_word),
        .si_override  (si_override),
        .sa_override  (sa_override),
        .out_valid    (TX_TS0_VALID),
        .out_data     (TX_TS0_DATA),
        .align_flag   (TX_ALIGN_FLAG)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    rx_align_read_a: assert property ( // RULE_08
        RX_TS0_VALID && RX_TS0_ALIGN ##1 HOST_RD && HOST_ADDR == e1oba_pkg::OFS_RX_ALIGN_WORD
        |=> HOST_RDATA == $past(RX_TS0_DATA, 2))
        else $error("receive align word read back wrong");

    rx_nonalign_map_a: assert property ( // RULE_09
        RX_TS0_VALID && !RX_TS0_ALIGN ##1 !RX_TS0_VALID [*2] ##1 RX_TS0_VALID && RX_TS0_ALIGN
        |=> rx_nonalign_word == $past(RX_TS0_DATA, 4))
        else $error("receive non-align word layout wrong");

    rx_flag_pulse_a: assert property ( // RULE_02
        RX_ALIGN_FLAG |-> !$past(RX_ALIGN_FLAG) || $past(RX_TS0_VALID && RX_TS0_ALIGN))
        else $error("receive flag stretched");

    tx_write_a: assert property ( // RULE_10
        HOST_WR && HOST_ADDR == e1oba_pkg::OFS_TX_ALIGN_WORD |=> tx_align_word == $past(HOST_WDATA))
        else $error("transmit align word write lost");

    // word was sampled at the align request, one edge before the flag
    tx_alarm_bit_a: assert property ( // RULE_12
        TX_ALIGN_FLAG ##1 TX_TS0_REQ && !TX_TS0_ALIGN
        |=> TX_TS0_DATA[e1oba_pkg::RAI_BIT] == $past(tx_nonalign_word[e1oba_pkg::RAI_BIT], 3)
            && TX_TS0_DATA[e1oba_pkg::NAM_BIT] == $past(tx_nonalign_word[e1oba_pkg::NAM_BIT], 3))
        else $error("remote alarm or marker bit not from sampled word");

    tx_flag_cause_a: assert property ( // RULE_14
        TX_TS0_REQ && TX_TS0_ALIGN |=> TX_ALIGN_FLAG && TX_TS0_VALID)
        else $error("transmit flag missing at align frame");

    tx_flag_only_a: assert property ( // RULE_04
        !(TX_TS0_REQ && TX_TS0_ALIGN) |=> !TX_ALIGN_FLAG)
        else $error("transmit flag without align frame");

    read_unmapped_a: assert property (
        HOST_RD && HOST_ADDR != e1oba_pkg::OFS_TX_ALIGN_WORD
        && HOST_ADDR != e1oba_pkg::OFS_TX_NONALIGN_WORD
        && HOST_ADDR != e1oba_pkg::OFS_RX_ALIGN_WORD
        && HOST_ADDR != e1oba_pkg::OFS_RX_NONALIGN_WORD
        |=> HOST_RDATA == e1oba_pkg::READ_UNMAPPED)
        else $error("unmapped read returned data");

    // an unwritten word is still the host value, so it goes out again
    tx_retransmit_a: assert property ( // RULE_05
        TX_TS0_REQ && TX_TS0_ALIGN && !si_override
        |=> TX_TS0_DATA == $past(tx_align_word))
        else $error("old transmit word not resent");

    rx_frames_c:   cover property (RX_TS0_VALID && !RX_TS0_ALIGN ##[1:20] RX_ALIGN_FLAG);
    tx_frames_c:   cover property (TX_ALIGN_FLAG ##[1:20] TX_TS0_REQ && !TX_TS0_ALIGN);
    sa_replace_c:  cover property (TX_TS0_REQ && !TX_TS0_ALIGN && sa_override);
    si_replace_c:  cover property (TX_TS0_REQ && si_override);
    rx_read_c:     cover property (RX_ALIGN_FLAG ##[1:10]
                                   HOST_RD && HOST_ADDR == e1oba_pkg::OFS_RX_NONALIGN_WORD);
endmodule

// file: dv/e1oba_host_model.sv
`timescale 1ns/1ps
module e1oba_host_model (
    input  wire logic       clk,
    input  wire logic [7:0] rdata,
    output logic [7:0]      addr,
    output logic [7:0]      wdata,
    output logic            wr,
    output logic            rd
);
    initial begin
        addr  = 8'h00;
        wdata = 8'h00;
        wr    = 1'h0;
        rd    = 1'h0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // random think time: a slow host, still far inside its service window
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        repeat ($urandom % 3) @(negedge clk);
        @(negedge clk);
        addr  = a;
        wdata = d;
        wr    = 1'h1;
        @(negedge clk);
        wr    = 1'h0;
        addr  = ~a;
        wdata = ~d;
    endtask
    // data is taken a full cycle after the strobe, it stands until the next read
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        addr = a;
        rd   = 1'h1;
        @(negedge clk);
        rd   = 1'h0;
        addr = ~a;
        @(negedge clk);
        d = rdata;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // the device never fills in the fixed pattern or marker, so the host must
    task automatic load_tx(output logic [7:0] a, output logic [7:0] n);
        a = {1'($urandom), e1oba_pkg::FAS_PATTERN};
        n = 8'($urandom) | 8'h40;
        wr_reg(e1oba_pkg::OFS_TX_ALIGN_WORD, a);
        wr_reg(e1oba_pkg::OFS_TX_NONALIGN_WORD, n);
    endtask
    task automatic fetch_rx(output logic [7:0] a, output logic [7:0] n);
        rd_reg(e1oba_pkg::OFS_RX_ALIGN_WORD, a);
        rd_reg(e1oba_pkg::OFS_RX_NONALIGN_WORD, n);
    endtask
endmodule

// file: dv/e1_overhead_bit_access_test.sv
`timescale 1ns/1ps
module e1_overhead_bit_access_test;
    logic       mclk;
    logic       rst_n;
    logic [7:0] haddr;
    logic [7:0] hwdata;
    logic       hwr;
    logic       hrd;
    logic [7:0] rdata;
    logic       rx_valid;
    logic       rx_align;
    logic [7:0] rx_data;
    logic       tx_req;
    logic       tx_align;
    logic       si_alt;
    logic [4:0] sa_alt;
    logic       si_serial;
    logic       crc4_en;
    logic       auto_ebit;
    logic [7:0] ctrl;
    logic       tx_valid;
    logic [7:0] tx_data;
    logic       rx_flag;
    logic       tx_flag;
    int         err_total;
    int         checks;

    e1oba_top e1oba_top_i (.MCLK(mclk), .RST_N(rst_n), .HOST_ADDR(haddr),
        .HOST_WDATA(hwdata), .HOST_WR(hwr), .HOST_RD(hrd), .HOST_RDATA(rdata),
        .RX_TS0_VALID(rx_valid), .RX_TS0_ALIGN(rx_align), .RX_TS0_DATA(rx_data),
        .TX_TS0_REQ(tx_req), .TX_TS0_ALIGN(tx_align), .TX_SI_ALT(si_alt),
        .TX_SA_ALT(sa_alt), .TX_SI_SERIAL(si_serial), .TX_CRC4_EN(crc4_en),
        .TX_AUTO_EBIT(auto_ebit), .TX_CTRL_REG(ctrl), .TX_TS0_VALID(tx_valid),
        .TX_TS0_DATA(tx_data), .RX_ALIGN_FLAG(rx_flag), .TX_ALIGN_FLAG(tx_flag));
    e1oba_host_model e1oba_host_model_i (.clk(mclk), .rdata(rdata), .addr(haddr),
        .wdata(hwdata), .wr(hwr), .rd(hrd));

    always #4 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    function automatic logic [7:0] tx_exp(input logic [7:0] w, input logic al);
        logic [7:0] e;
        e = w;
        if (si_serial | crc4_en | auto_ebit) e[e1oba_pkg::SI_BIT] = si_alt;
        if (!al && (|ctrl[7:3])) e[4:0] = sa_alt;
        return e;
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    task automatic rx_octet(input logic al, input logic [7:0] d);
        @(negedge mclk);
        rx_valid = 1'h1;
        rx_align = al;
        rx_data  = d;
        @(negedge mclk);
        rx_valid = 1'h0;
        rx_align = ~al;
        rx_data  = ~d;
        check({7'h00, rx_flag}, {7'h00, al});
        @(negedge mclk);
        check({7'h00, rx_flag}, 8'h00);
    endtask
    task automatic tx_frame(input logic al, input logic [7:0] w);
        @(negedge mclk);
        tx_req   = 1'h1;
        tx_align = al;
        @(negedge mclk);
        tx_req   = 1'h0;
        tx_align = ~al;
        check({6'h00, tx_valid, tx_flag}, {6'h00, 1'h1, al});
        check(tx_data, tx_exp(w, al));
        @(negedge mclk);
        check({6'h00, tx_valid, tx_flag}, 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (60000) @(posedge mclk);
        err_total++;
        stop_test();
    end
    initial begin
        logic [7:0] pa, pn, sn, ra, rn, n, a;
        logic [7:0] adr [4] = '{e1oba_pkg::OFS_TX_ALIGN_WORD, e1oba_pkg::OFS_TX_NONALIGN_WORD,
                                e1oba_pkg::OFS_RX_ALIGN_WORD, e1oba_pkg::OFS_RX_NONALIGN_WORD};
        logic [7:0] rst [4] = '{e1oba_pkg::RST_TX_ALIGN_WORD, e1oba_pkg::RST_TX_NONALIGN_WORD,
                                e1oba_pkg::RST_RX_WORD, e1oba_pkg::RST_RX_WORD};
        {mclk, rst_n, rx_valid, rx_align, tx_req, tx_align} = 6'h00;
        {si_alt, sa_alt, si_serial, crc4_en, auto_ebit} = 9'h000;
        {rx_data, ctrl} = 16'h0000;
        err_total = 0;
        checks = 0;
        void'($urandom(97));
        repeat (10) @(posedge mclk);
        check({5'h00, tx_valid, tx_flag, rx_flag}, 8'h00);
        @(negedge mclk);
        rst_n = 1'h1;
        // reset values, read-only words refuse writes, unmapped reads give zero
        for (int k = 0; k < 4; k++) begin
            e1oba_host_model_i.rd_reg(adr[k], ra);
            check(ra, rst[k]);
        end
        e1oba_host_model_i.wr_reg(e1oba_pkg::OFS_RX_ALIGN_WORD, 8'hA5);
        e1oba_host_model_i.wr_reg(e1oba_pkg::OFS_RX_NONALIGN_WORD, 8'h5A);
        e1oba_host_model_i.fetch_rx(ra, rn);
        check(ra, e1oba_pkg::RST_RX_WORD);
        check(rn, e1oba_pkg::RST_RX_WORD);
        e1oba_host_model_i.rd_reg(8'h3F, ra);
        check(ra, e1oba_pkg::READ_UNMAPPED);
        pa = e1oba_pkg::RST_TX_ALIGN_WORD;
        pn = e1oba_pkg::RST_TX_NONALIGN_WORD;
        for (int i = 0; i < 40; i++) begin
            // first passes walk each override source and each control bit alone
            {si_serial, crc4_en, auto_ebit} = 3'((i < 4) ? (4'h1 << i) : $urandom);
            ctrl = (i < 5) ? (8'h08 << i) : (i < 8) ? 8'($urandom % 8) : 8'($urandom);
            si_alt = 1'($urandom);
            sa_alt = 5'($urandom);
            n = 8'($urandom);
            a = 8'($urandom);
            rx_octet(1'h0, n);
            rx_octet(1'h1, a);
            e1oba_host_model_i.fetch_rx(ra, rn);
            check(ra, a);
            check(rn, n);
            tx_frame(1'h1, pa);
            sn = pn;
            // every third pass the host misses its update and old words go out
            if (i % 3 != 2) begin
                e1oba_host_model_i.load_tx(pa, pn);
            end
            tx_frame(1'h0, sn);
            e1oba_host_model_i.rd_reg(e1oba_pkg::OFS_TX_NONALIGN_WORD, ra);
            check(ra, pn);
        end
        stop_test();
    end
endmodule
